// *** core/etxpm_top.sv ***
// Purpose: transmit pacing and link-mode selection for one 10/100 MAC channel
// Assumes: one 20 MHz clock; line-side status inputs come from other clock domains
// Notes: registers over AXI4-Lite; gaps are counted in nibble times
//
// Overview of operation
// RULE1: extra gap after receive when enabled
// RULE2: disabled: only the two standard parts
// RULE3: extra-gap enable single bit, resets to 1
// RULE4: post-receive gap 0..31 nibbles, 0 adds none
// RULE5: nibble is 400 ns slow, 40 ns fast (the code's fast nibble is one 50 ns aclk cycle)
// RULE6: post-receive gap resets to 16 nibbles
// RULE7: burst limit 1..255 caps, 0 unlimited
// RULE8: autoneg bit: 0 forced, 1 autoneg, reset 1
// RULE9: advertisement resets: 1, 1, 0, 1
// RULE10: priority fast full, four pair, fast half, slow full, slow half
// RULE11: local capability bits read-only, loaded at startup
// RULE12: partner bits read zero without partner autoneg
// RULE13: standard gap is first plus second byte parts
// RULE14: transmit waits until every gap count expires
// RULE15: burst counter clears after idle past gap
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "etxpm_regs.svh"

module etxpm_top
	import etxpm_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// mac side, same clock
	input wire logic tx_request,
	input wire logic tx_done,
	input wire logic rx_end,
	output logic tx_start,
	// transceiver side, asynchronous levels
	input wire logic link_fast,
	input wire logic [4:0] local_able_pins,
	input wire logic [4:0] partner_able_pins,
	// chosen mode toward the transceiver
	output logic [5:0] adv_out,
	output logic [4:0] mode_chosen
);

	// =====================================================================
	// register state
	etxpm_gap_t gap_ff; // gap settings
	logic [7:0] pace_ff; // burst limit
	etxpm_adv_t adv_ff; // advertisement bits
	logic [4:0] local_ff; // startup capability snapshot
	logic [1:0] startup_ff; // edges since release; snapshot is final at three
	logic [4:0] partner_ff; // partner abilities, masked

	// =====================================================================
	// synchronisers for line-side levels
	logic [10:0] sync1_ff; // first stage, read only by second
	logic [10:0] sync2_ff; // second stage

	// two flops before any logic reads a pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 11'h000;
			sync2_ff <= 11'h000;
		end else begin
			sync1_ff <= {link_fast, local_able_pins, partner_able_pins};
			sync2_ff <= sync1_ff;
		end
	end

	// =====================================================================
	// helpers
	// chosen mode, one-hot, in descending priority order
	function automatic logic [4:0] pick_mode(input etxpm_adv_t a);
		logic [4:0] m;
		m = 5'h00;
		if (a.fast_full) begin
			m = 5'h10;
		end else if (a.fast_four_pair) begin
			m = 5'h08;
		end else if (a.fast_half) begin
			m = 5'h04;
		end else if (a.slow_full) begin
			m = 5'h02;
		end else if (a.slow_half) begin
			m = 5'h01;
		end
		return m;
	endfunction

	// byte-lane merge for a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// =====================================================================
	// axi4-lite write path: address and data accepted in either order
	logic aw_held_ff; // address captured
	logic w_held_ff; // data captured
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;

	assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

	// capture each channel once, ready drops while it is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response; unmapped or read-only offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ETXPM_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_ff == `ETXPM_OFS_GAP || awaddr_ff == `ETXPM_OFS_PACE ||
				awaddr_ff == `ETXPM_OFS_ADV) ? `ETXPM_RESP_OKAY : `ETXPM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// =====================================================================
	// writable settings
	logic [31:0] gap_word;
	assign gap_word = merge({7'h00, gap_ff.extra_en, 3'h0, gap_ff.post_rx, gap_ff.second, gap_ff.first},
		wdata_ff, wstrb_ff);

	// settings update; reset values chosen as the documented defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// RULE3: extra-gap enable default
			gap_ff.extra_en <= `ETXPM_RST_EXTRA;
			// RULE6: post-receive default
			gap_ff.post_rx <= `ETXPM_RST_POST;
			// RULE13: standard gap defaults
			gap_ff.first <= `ETXPM_RST_FIRST;
			gap_ff.second <= `ETXPM_RST_SECOND;
			// RULE7: no limit by default
			pace_ff <= `ETXPM_RST_PACE;
			// RULE8: autoneg by default
			// RULE9: advertisement defaults
			adv_ff <= `ETXPM_RST_ADV;
		end else if (do_write) begin
			case (awaddr_ff)
				`ETXPM_OFS_GAP: begin
					gap_ff.first <= gap_word[`ETXPM_GAP_FIRST_LSB +: 8];
					gap_ff.second <= gap_word[`ETXPM_GAP_SECOND_LSB +: 8];
					// RULE4: five bits hold 0..31
					gap_ff.post_rx <= gap_word[`ETXPM_GAP_POST_LSB +: 5];
					gap_ff.extra_en <= gap_word[`ETXPM_GAP_EXTRA_BIT];
				end
				`ETXPM_OFS_PACE: begin
					if (wstrb_ff[0]) begin
						pace_ff <= wdata_ff[7:0];
					end
				end
				`ETXPM_OFS_ADV: begin
					if (wstrb_ff[0]) begin
						adv_ff <= wdata_ff[5:0];
					end
				end
				default: begin
					// read-only or unmapped: nothing stored
				end
			endcase
		end
	end

	// =====================================================================
	// capability reporting
	// snapshot keeps loading until the synchronisers hold real pin values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			startup_ff <= 2'h0;
			local_ff <= 5'h00;
			partner_ff <= 5'h00;
		end else begin
			// RULE11: loaded once at startup
			if (startup_ff != 2'h3) begin
				startup_ff <= startup_ff + 2'h1;
				local_ff <= sync2_ff[9:5];
			end
			// RULE12: all zero without partner autoneg
			partner_ff <= sync2_ff[4] ? sync2_ff[4:0] : 5'h00;
		end
	end

	// chosen mode and advertisement toward the transceiver
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adv_out <= 6'h00;
			mode_chosen <= 5'h00;
		end else begin
			adv_out <= adv_ff;
			// RULE10: priority pick
			mode_chosen <= pick_mode(adv_ff);
		end
	end

	// =====================================================================
	// read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ETXPM_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `ETXPM_RESP_OKAY;
				case (s_axi_araddr)
					`ETXPM_OFS_GAP: s_axi_rdata <= {7'h00, gap_ff.extra_en, 3'h0, gap_ff.post_rx,
						gap_ff.second, gap_ff.first};
					`ETXPM_OFS_PACE: s_axi_rdata <= {24'h000000, pace_ff};
					`ETXPM_OFS_ADV: s_axi_rdata <= {26'h0000000, adv_ff};
					`ETXPM_OFS_LOCAL: s_axi_rdata <= {27'h0000000, local_ff};
					`ETXPM_OFS_PARTNER: s_axi_rdata <= {27'h0000000, partner_ff};
					`ETXPM_OFS_STATUS: s_axi_rdata <= {27'h0000000, mode_chosen};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `ETXPM_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// =====================================================================
	// pacing engine
	etxpm_state_t state_ff;
	logic [3:0] nib_tick_ff; // cycles within one nibble time
	logic nib_pulse;
	logic [10:0] gap_left_ff; // nibbles owed; 11 bits since both parts at 255 plus 31 exceed 1023
	logic [9:0] idle_nib_ff; // nibbles idle since last transmit
	logic [7:0] burst_ff; // packets sent back to back
	logic [9:0] std_gap_nib;
	logic post_pending_ff; // a receive ended since the last transmit

	// RULE5: nibble length follows link speed
	// at-or-above, so a switch to fast mid-count ends the nibble at once instead of wrapping
	assign nib_pulse = (nib_tick_ff >= 4'((sync2_ff[10] ? `ETXPM_NIB_FAST_CYC : `ETXPM_NIB_SLOW_CYC) - 1));
	// RULE13: total standard gap in nibbles
	assign std_gap_nib = 10'((gap_ff.first + gap_ff.second) * `ETXPM_NIB_PER_BYTE);

	// free-running nibble timebase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nib_tick_ff <= 4'h0;
		end else begin
			nib_tick_ff <= nib_pulse ? 4'h0 : nib_tick_ff + 4'h1;
		end
	end

	// gap countdown and state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ETXPM_IDLE;
			gap_left_ff <= 11'h000;
			post_pending_ff <= 1'b0;
			tx_start <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			if (rx_end) begin
				post_pending_ff <= 1'b1;
			end
			case (state_ff)
				ETXPM_IDLE: begin
					if (tx_request) begin
						// RULE1: add post-receive part when enabled
						// RULE2: disabled ignores the setting
						gap_left_ff <= 11'(std_gap_nib) + ((gap_ff.extra_en && (post_pending_ff || rx_end)) ?
							11'(gap_ff.post_rx) : 11'h000);
						state_ff <= ETXPM_WAIT;
					end
				end
				ETXPM_WAIT: begin
					// RULE14: receive end with the extra gap enabled restarts the whole wait, standard plus post-receive
					if (rx_end && gap_ff.extra_en) begin
						gap_left_ff <= 11'(std_gap_nib) + 11'(gap_ff.post_rx);
					end else if (gap_left_ff == 11'h000) begin
						tx_start <= 1'b1;
						if (!rx_end) begin
							post_pending_ff <= 1'b0;
						end
						state_ff <= ETXPM_SEND;
					end else if (nib_pulse) begin
						gap_left_ff <= gap_left_ff - 11'h001;
					end
				end
				ETXPM_SEND: begin
					if (tx_done) begin
						// RULE7: stop at the burst limit
						state_ff <= (pace_ff != 8'h00 && burst_ff + 8'h01 >= pace_ff) ? ETXPM_HOLD : ETXPM_IDLE;
					end
				end
				ETXPM_HOLD: begin
					// limit reached: wait for the counter to clear
					if (burst_ff == 8'h00) begin
						state_ff <= ETXPM_IDLE;
					end
				end
				default: state_ff <= ETXPM_IDLE;
			endcase
		end
	end

	// burst counter and idle time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_ff <= 8'h00;
			idle_nib_ff <= 10'h000;
		end else if (state_ff == ETXPM_SEND) begin
			idle_nib_ff <= 10'h000;
			if (tx_done && burst_ff != 8'hff) begin
				burst_ff <= burst_ff + 8'h01;
			end
		end else if (state_ff == ETXPM_WAIT) begin
			// the paced gap itself is not idle time, else no burst could ever build up
			idle_nib_ff <= 10'h000;
		end else if (idle_nib_ff > std_gap_nib) begin
			// RULE15: long idle clears the burst
			burst_ff <= 8'h00;
		end else if (nib_pulse) begin
			idle_nib_ff <= idle_nib_ff + 10'h001;
		end
	end

	// =====================================================================
	// checks
	sequence s_launch;
		state_ff == ETXPM_WAIT && gap_left_ff == 11'h000 && !(rx_end && gap_ff.extra_en);
	endsequence

	AST_START_ONLY_AFTER_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		tx_start |-> $past(gap_left_ff) == 11'h000)
		else $error("transmit started with gap remaining");
	AST_LAUNCH_PULSE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		s_launch |=> tx_start ##1 !tx_start)
		else $error("launch not a single pulse");
	AST_NO_EXTRA_WHEN_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		state_ff == ETXPM_IDLE && tx_request && !gap_ff.extra_en |=> gap_left_ff == 11'($past(std_gap_nib)))
		else $error("extra gap added while disabled");
	AST_EXTRA_WHEN_ON: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
		state_ff == ETXPM_IDLE && tx_request && gap_ff.extra_en && post_pending_ff
		|=> gap_left_ff == 11'($past(std_gap_nib)) + 11'($past(gap_ff.post_rx)))
		else $error("post-receive gap missing");
	AST_FAST_NIBBLE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		sync2_ff[10] && $past(sync2_ff[10]) |-> nib_pulse)
		else $error("fast nibble not one cycle");
	AST_SLOW_NIBBLE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		nib_pulse && !sync2_ff[10] |=> (!nib_pulse || sync2_ff[10]) [*7])
		else $error("slow nibble shorter than eight cycles");
	AST_BURST_CAP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
		pace_ff != 8'h00 && burst_ff >= pace_ff |-> !tx_start)
		else $error("burst limit exceeded");
	AST_HOLD_AT_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
		state_ff == ETXPM_SEND && tx_done && pace_ff == 8'h02 && burst_ff == 8'h01 |=> state_ff == ETXPM_HOLD)
		else $error("limit of two not held");
	AST_PARTNER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
		!partner_ff[4] |-> partner_ff == 5'h00)
		else $error("partner bits set without autoneg");
	AST_PRIORITY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
		adv_ff.fast_full && $past(adv_ff.fast_full) && $past(aresetn) |-> mode_chosen == 5'h10)
		else $error("fast full not preferred");

endmodule

// *** core/etxpm_regs.svh ***
// Purpose: register offsets, field positions, reset values and timing counts for the tx pacing block
// Assumes: 20 MHz aclk, 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef ETXPM_REGS_SVH
`define ETXPM_REGS_SVH

// =====================================================================
// register byte offsets
`define ETXPM_OFS_GAP      12'h000
`define ETXPM_OFS_PACE     12'h004
`define ETXPM_OFS_ADV      12'h008
`define ETXPM_OFS_LOCAL    12'h00c
`define ETXPM_OFS_PARTNER  12'h010
`define ETXPM_OFS_STATUS   12'h014

// =====================================================================
// gap register fields
`define ETXPM_GAP_FIRST_LSB   0
`define ETXPM_GAP_SECOND_LSB  8
`define ETXPM_GAP_POST_LSB    16
`define ETXPM_GAP_EXTRA_BIT   24

// =====================================================================
// reset values
`define ETXPM_RST_FIRST   8'h08
`define ETXPM_RST_SECOND  8'h04
`define ETXPM_RST_POST    5'h10
`define ETXPM_RST_EXTRA   1'h1
`define ETXPM_RST_PACE    8'h00
`define ETXPM_RST_ADV     6'h35

// =====================================================================
// timing: one nibble time in ns per speed, clock period in ns
`define ETXPM_CLK_NS          50
`define ETXPM_NIBBLE_SLOW_NS  400
`define ETXPM_NIBBLE_FAST_NS  40
// nibble counts in cycles; 40 ns rounds down to the one-cycle floor
`define ETXPM_NIB_SLOW_CYC  ((`ETXPM_NIBBLE_SLOW_NS / `ETXPM_CLK_NS) < 1 ? 1 : (`ETXPM_NIBBLE_SLOW_NS / `ETXPM_CLK_NS))
`define ETXPM_NIB_FAST_CYC  ((`ETXPM_NIBBLE_FAST_NS / `ETXPM_CLK_NS) < 1 ? 1 : (`ETXPM_NIBBLE_FAST_NS / `ETXPM_CLK_NS))
`define ETXPM_NIB_PER_BYTE  2
`define ETXPM_RESP_OKAY    2'h0
`define ETXPM_RESP_SLVERR  2'h2

`endif

// *** core/etxpm_pkg.sv ***
// Purpose: types for the tx pacing block
// Assumes: nothing
// Notes: offsets and counts live in etxpm_regs.svh
package etxpm_pkg;

	// advertisement set, highest priority first in the chosen-mode encoding
	typedef struct packed {
		logic autoneg;
		logic fast_full;
		logic fast_four_pair;
		logic fast_half;
		logic slow_full;
		logic slow_half;
	} etxpm_adv_t;

	// gap settings
	typedef struct packed {
		logic extra_en;
		logic [4:0] post_rx;
		logic [7:0] second;
		logic [7:0] first;
	} etxpm_gap_t;

	// pacing states, one-hot
	typedef enum logic [3:0] {
		ETXPM_IDLE = 4'b0001,
		ETXPM_WAIT = 4'b0010,
		ETXPM_SEND = 4'b0100,
		ETXPM_HOLD = 4'b1000
	} etxpm_state_t;

endpackage

// *** dv/etxpm_phy_model.sv ***
// Purpose: transceiver stand-in: link speed, local and partner ability pins
// Assumes: levels change just after a clock edge, like real async pins seen late
// Notes: partner pins are scrambled while the partner cannot negotiate
`timescale 1ns/1ns
module etxpm_phy_model #(
	parameter logic [4:0] LOCAL_ABLE = 5'h1b
) (
	// clock
	input wire logic aclk,
	// scenario controls from the bench
	input wire logic fast_sel,
	input wire logic local_swap,
	input wire logic partner_an,
	input wire logic [3:0] partner_modes,
	// pins toward the block
	output logic link_fast,
	output logic [4:0] local_able_pins,
	output logic [4:0] partner_able_pins
);
	// =====================================================================
	// pin drivers
	// line speed level, held between scenarios
	always @(posedge aclk) begin
		link_fast <= fast_sel;
	end

	// local abilities fixed unless local_swap inverts them
	// swapping later checks that only the startup snapshot is reported
	always @(posedge aclk) begin
		local_able_pins <= local_swap ? ~LOCAL_ABLE : LOCAL_ABLE;
	end

	// partner abilities meaningless without negotiation
	// inverted modes instead of a clean zero, so masking must be real
	always @(posedge aclk) begin
		if (partner_an) begin
			partner_able_pins <= {1'b1, partner_modes};
		end else begin
			partner_able_pins <= {1'b0, ~partner_modes};
		end
	end
endmodule

// *** dv/etxpm_top_tb_top.sv ***
// Purpose: self-checking bench for the tx pacing and mode select block
// Assumes: fast nibble is one cycle, slow nibble eight cycles of aclk
// Notes: pacing latency allows a nibble of slack, the timebase runs free
`timescale 1ns/1ns
`include "etxpm_regs.svh"
module etxpm_top_tb_top
	import etxpm_pkg::*;
;
	// =====================================================================
	// signals
	localparam logic [4:0] LOCAL_ABLE = 5'h1b;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic tx_request = 1'b0, tx_done = 1'b0, rx_end = 1'b0, tx_start;
	logic fast_sel = 1'b1, local_swap = 1'b0, partner_an = 1'b0;
	logic [3:0] partner_modes = 4'h0;
	logic link_fast;
	logic [4:0] local_able_pins, partner_able_pins, mode_chosen;
	logic [5:0] adv_out;
	int error_cnt = 0, check_count = 0, n;

	// 20 MHz clock
	always #25 aclk = ~aclk;

	// =====================================================================
	// block and transceiver stand-in
	etxpm_top etxpm_top_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_request(tx_request), .tx_done(tx_done), .rx_end(rx_end), .tx_start(tx_start),
		.link_fast(link_fast), .local_able_pins(local_able_pins), .partner_able_pins(partner_able_pins),
		.adv_out(adv_out), .mode_chosen(mode_chosen)
	);
	etxpm_phy_model #(.LOCAL_ABLE(LOCAL_ABLE)) etxpm_phy_model_i (
		.aclk(aclk), .fast_sel(fast_sel), .local_swap(local_swap), .partner_an(partner_an),
		.partner_modes(partner_modes), .link_fast(link_fast), .local_able_pins(local_able_pins),
		.partner_able_pins(partner_able_pins)
	);

	// =====================================================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// read: rready held until the data beat is sampled
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	function automatic logic [31:0] gapw(input logic en, input logic [4:0] post, input logic [7:0] sec,
		input logic [7:0] first);
		return {7'h0, en, 3'h0, post, sec, first};
	endfunction

	function automatic logic near(input int got, input int want, input int tol);
		return (got >= want - tol) && (got <= want + tol);
	endfunction

	// one packet: optional receive end, request held until start, then done
	task automatic send(input logic rx, output int lat);
		if (rx) begin
			@(posedge aclk);
			rx_end <= 1'b1;
			@(posedge aclk);
			rx_end <= 1'b0;
		end
		@(posedge aclk);
		tx_request <= 1'b1;
		lat = 0;
		do begin
			@(posedge aclk);
			lat++;
		end while (tx_start !== 1'b1);
		tx_request <= 1'b0;
		@(posedge aclk);
		tx_done <= 1'b1;
		@(posedge aclk);
		tx_done <= 1'b0;
	endtask

	// latency is about three cycles of pipeline plus the gap in cycles
	task automatic paced(input logic rx, input int want, input int tol);
		send(rx, n);
		chk({31'h0, near(n, want, tol)}, 32'h1);
	endtask

	task automatic tally_and_finish;
		$display("mismatches %0d, comparisons %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		// reset values, then read-only and unmapped places
		rd(`ETXPM_OFS_GAP, 32'h0110_0408, 2'h0);
		rd(`ETXPM_OFS_PACE, 32'h0, 2'h0);
		rd(`ETXPM_OFS_ADV, 32'h35, 2'h0);
		chk({26'h0, adv_out}, 32'h35);
		local_swap <= 1'b1;
		wr(`ETXPM_OFS_LOCAL, 32'h0, 2'h2);
		rd(`ETXPM_OFS_LOCAL, {27'h0, LOCAL_ABLE}, 2'h0);
		rd(12'h018, 32'h0, 2'h2);
		wr(12'h018, 32'hffff_ffff, 2'h2);
		// partner abilities masked, then shown
		rd(`ETXPM_OFS_PARTNER, 32'h0, 2'h0);
		partner_an <= 1'b1;
		partner_modes <= 4'ha;
		repeat (6) @(posedge aclk);
		rd(`ETXPM_OFS_PARTNER, 32'h1a, 2'h0);
		// forced mode, lower modes also set: the highest one must win
		for (int i = 0; i < 5; i++) begin
			wr(`ETXPM_OFS_ADV, (32'h2 << i) - 32'h1, 2'h0);
			repeat (4) @(posedge aclk);
			chk({27'h0, mode_chosen}, 32'h1 << i);
			rd(`ETXPM_OFS_STATUS, 32'h1 << i, 2'h0);
		end
		chk({26'h0, adv_out}, 32'h1f);
		// fast link pacing: standard gap is 6 nibbles
		wr(`ETXPM_OFS_GAP, gapw(1'b0, 5'h14, 8'h01, 8'h02), 2'h0);
		rd(`ETXPM_OFS_GAP, gapw(1'b0, 5'h14, 8'h01, 8'h02), 2'h0);
		paced(1'b1, 3 + 6, 3);
		wr(`ETXPM_OFS_GAP, gapw(1'b1, 5'h14, 8'h01, 8'h02), 2'h0);
		paced(1'b1, 3 + 26, 3);
		paced(1'b0, 3 + 6, 3);
		wr(`ETXPM_OFS_GAP, gapw(1'b1, 5'h00, 8'h01, 8'h02), 2'h0);
		paced(1'b1, 3 + 6, 3);
		wr(`ETXPM_OFS_GAP, gapw(1'b1, 5'h1f, 8'h01, 8'h02), 2'h0);
		paced(1'b1, 3 + 37, 3);
		// slow link: eight cycles a nibble
		fast_sel <= 1'b0;
		wr(`ETXPM_OFS_GAP, gapw(1'b1, 5'h10, 8'h00, 8'h00), 2'h0);
		repeat (6) @(posedge aclk);
		paced(1'b1, 3 + 128, 10);
		wr(`ETXPM_OFS_GAP, gapw(1'b0, 5'h10, 8'h01, 8'h00), 2'h0);
		paced(1'b1, 3 + 16, 10);
		fast_sel <= 1'b1;
		// burst limit: standard gap 8 nibbles, first unlimited then two
		wr(`ETXPM_OFS_GAP, gapw(1'b0, 5'h00, 8'h00, 8'h04), 2'h0);
		repeat (6) @(posedge aclk);
		for (int i = 0; i < 3; i++) paced(1'b0, 3 + 8, 3);
		wr(`ETXPM_OFS_PACE, 32'h2, 2'h0);
		repeat (30) @(posedge aclk);
		for (int i = 0; i < 2; i++) paced(1'b0, 3 + 8, 3);
		send(1'b0, n);
		chk({31'h0, n > 14}, 32'h1);
		// a long idle clears the count: two more go without holding
		repeat (30) @(posedge aclk);
		for (int i = 0; i < 2; i++) paced(1'b0, 3 + 8, 3);
		tally_and_finish;
	end

	// watchdog: the whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		tally_and_finish;
	end
endmodule
